// [rtl/qaw_pkg.sv]
// package for the question-and-answer window watchdog registers, plus its question generator
// assumes a single 250 MHz core clock and an asynchronous active-high reset
package qaw_pkg;
    // clock and window step timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int WIN_STEP_NS = 1000;
    localparam int WIN_STEP_CYCLES = (WIN_STEP_NS * 1000) / CLK_PERIOD_PS;
    // reset values
    localparam logic [7:0] QGEN_CFG_RST = 8'h00;
    localparam logic [7:0] WIN1_CFG_RST = 8'h7F;
    localparam logic [7:0] WIN2_CFG_RST = 8'h18;
    localparam logic [1:0] ANS_CNT_RST = 2'h3;
    // field positions
    localparam int QUESTION_FEEDBACK_CFG_LSB = 4;
    localparam int SEED_LSB = 0;
    localparam int WIN1_W = 7;
    localparam int WIN2_W = 5;
    localparam int FAIL_TH_BIT = 7;
    localparam int ST_CNT_LSB = 6;
    localparam int ST_AERR = 5;
    localparam int ST_ZERO = 4;
    localparam int ST_CHG = 3;
    localparam int ST_SEQ = 2;
    localparam int ST_TOUT = 1;
    localparam int ST_EARLY = 0;
    localparam logic [2:0] FAIL_TH_LIMIT = 3'h5;
    localparam logic [2:0] ANSWERS_PER_SEQ = 3'h4;
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        SEL_QGEN_CFG, SEL_WIN1_CFG, SEL_WIN2_CFG, SEL_QUESTION, SEL_STATUS, SEL_ANSWER
    } qaw_reg_sel_t;

    // one register access from the serial command decoder
    typedef struct packed {
        logic wr;
        logic rd;
        qaw_reg_sel_t sel;
        logic [7:0] wdata;
    } qaw_reg_req_t;

    typedef enum logic {PH_WIN1, PH_WIN2} qaw_phase_t;

    typedef struct packed {
        logic [7:0] qgen_cfg;
        logic [7:0] win1_cfg;
        logic [7:0] win2_cfg;
        logic lock;
        logic [2:0] pin_sync;
        logic trig_lvl;
        qaw_phase_t phase;
        logic [CNT_W-1:0] tick;
        logic [1:0] ans_cnt;
        logic [2:0] ans_total;
        logic trig_seen;
        logic seq_bad;
        logic aerr;
        logic chg;
        logic seqf;
        logic tout;
        logic early;
        logic good_evt;
        logic bad_evt;
        logic [7:0] rdata;
    } qaw_state_t;

    typedef struct packed {
        logic [3:0] token;
        logic [3:0] seed_act;
        logic rep;
    } qaw_qgen_state_t;

    // shift-register tap pattern chosen by the middle feedback pair
    function automatic logic [3:0] lfsr_taps(input logic [1:0] sel);
        unique case (sel)
            2'h0: lfsr_taps = 4'hC;
            2'h1: lfsr_taps = 4'h9;
            2'h2: lfsr_taps = 4'hA;
            2'h3: lfsr_taps = 4'h6;
        endcase
    endfunction

    // expected answer byte for a question and byte index
    function automatic logic [7:0] expected_answer(input logic [3:0] q, input logic [1:0] idx);
        expected_answer = {q ^ {2'h0, idx}, ~q};
    endfunction
endpackage

`timescale 1ns/1ps
`default_nettype none
module qaw_question_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic reinit,
    input wire logic load_seed,
    input wire logic [3:0] seed,
    input wire logic [3:0] question_feedback_cfg,
    input wire logic advance,
    // question out
    output logic [3:0] token
);
    import qaw_pkg::*;
    qaw_qgen_state_t s_ff, nxt_s;

    // xnor feedback so the all-zero seed still walks; upper bit doubles each question
    always_comb begin
        nxt_s = s_ff;
        if (load_seed) begin
            nxt_s.seed_act = seed;
            nxt_s.token = seed;
            nxt_s.rep = 1'b0;
        end else if (reinit) begin
            // self-test reinit restores the question to its reset value, not to the seed
            nxt_s.token = 4'h0;
            nxt_s.rep = 1'b0;
        end else if (advance) begin
            if (question_feedback_cfg[3] && !s_ff.rep) begin
                nxt_s.rep = 1'b1;
            end else begin
                nxt_s.rep = 1'b0;
                nxt_s.token = {s_ff.token[2:0], ~^(s_ff.token & lfsr_taps(question_feedback_cfg[2:1]))};
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign token = s_ff.token;
endmodule // qaw_question_gen
`default_nettype wire

// [rtl/qaw_regs.sv]
// register block of the window watchdog: config, question, status, answer port and sequencer
// assumes a serial command decoder presents one access per cycle and device state levels
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - config and window writes accepted only in diagnostic state and before lock
// - four-bit feedback field orders and repeats up to fifteen generated questions
// - top feedback bit steers generation, middle pair picks polynomial, bit0 reserved
// - new seed takes effect only while in reset state with self-test disabled
// - first window from seven low bits, top bit reserved
// - second window from five low bits, upper three reserved
// - fail-threshold flag reads one when fail counter is five or more
// - two-bit count of answer bytes received in current sequence
// - answer error sets on wrong byte, clears on correct byte or new sequence
// - zero-window flag is one when either window setting is zero
// - window-changed flag sets on window change, clears at next sequence
// - sequence fault sets on wrong answer value or wrong answer timing
// - time-out sets on missing trigger or fewer than four answers
// - time-out clears on status read, at a sequence end with trigger or four answers seen, and in reset
// - time-out writable to one in diagnostic state, acting as pin failure
// - early flag sets on answers completed or trigger inside first window
// - write-only eight-bit answer port
// - question and status return to reset values after self-test reinit
module qaw_regs #(
    parameter int WIN_STEP = qaw_pkg::WIN_STEP_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // register access
    input wire qaw_pkg::qaw_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // device state
    input wire logic diag_state,
    input wire logic in_reset_state,
    input wire logic auto_selftest_disable,
    input wire logic config_write_lock_cmd,
    input wire logic logic_selftest,
    input wire logic qa_mode,
    // safety inputs
    input wire logic [2:0] fail_counter,
    input wire logic error_trigger_pin,
    // watchdog events
    output logic good_event,
    output logic bad_event,
    output logic timeout_fail
);
    import qaw_pkg::*;
    qaw_state_t s_ff, nxt_s;
    logic [3:0] token;
    logic cfg_ok, trig_rise, ans_wr, correct, seq_end, got_evt, load_seed, advance;
    logic aerr_set, aerr_clr, chg_set, seqf_set, tout_set, tout_clr, early_set, fresh;
    logic [CNT_W-1:0] win_last;
    logic [7:0] rd_mux;
    logic zero_flag;

    assign zero_flag = (s_ff.win1_cfg[WIN1_W-1:0] == '0) || (s_ff.win2_cfg[WIN2_W-1:0] == '0);
    assign cfg_ok = diag_state && !s_ff.lock;
    assign load_seed = in_reset_state && auto_selftest_disable;
    assign ans_wr = reg_req.wr && (reg_req.sel == SEL_ANSWER) && qa_mode;
    assign correct = reg_req.wdata == expected_answer(token, s_ff.ans_cnt);

    // window end in cycles: (setting + 1) steps
    always_comb begin
        if (s_ff.phase == PH_WIN1) begin
            win_last = CNT_W'((int'(s_ff.win1_cfg[WIN1_W-1:0]) + 1) * WIN_STEP - 1);
        end else begin
            win_last = CNT_W'((int'(s_ff.win2_cfg[WIN2_W-1:0]) + 1) * WIN_STEP - 1);
        end
    end

    // read multiplexer; reserved bits and unmapped selects read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_req.sel)
            SEL_QGEN_CFG: rd_mux = s_ff.qgen_cfg;
            SEL_WIN1_CFG: rd_mux = s_ff.win1_cfg;
            SEL_WIN2_CFG: rd_mux = s_ff.win2_cfg;
            SEL_QUESTION: begin
                rd_mux[FAIL_TH_BIT] = fail_counter >= FAIL_TH_LIMIT;
                rd_mux[3:0] = token;
            end
            SEL_STATUS: begin
                rd_mux[ST_CNT_LSB+:2] = s_ff.ans_cnt;
                rd_mux[ST_AERR] = s_ff.aerr;
                rd_mux[ST_ZERO] = zero_flag;
                rd_mux[ST_CHG] = s_ff.chg;
                rd_mux[ST_SEQ] = s_ff.seqf;
                rd_mux[ST_TOUT] = s_ff.tout;
                rd_mux[ST_EARLY] = s_ff.early;
            end
            default: rd_mux = 8'h00; // answer port is write-only
        endcase
    end

    // next state: flag sets are applied after clears so a status flag set wins over every clear except self-test reinit
    always_comb begin
        nxt_s = s_ff;
        nxt_s.good_evt = 1'b0;
        nxt_s.bad_evt = 1'b0;
        aerr_set = 1'b0;
        aerr_clr = 1'b0;
        chg_set = 1'b0;
        seqf_set = 1'b0;
        tout_set = 1'b0;
        tout_clr = 1'b0;
        early_set = 1'b0;
        seq_end = 1'b0;
        got_evt = 1'b0;
        fresh = 1'b0;
        // pin: three stages, a level counts once stages two and three agree
        nxt_s.pin_sync = {s_ff.pin_sync[1:0], error_trigger_pin};
        trig_rise = (s_ff.pin_sync[1] == s_ff.pin_sync[2]) && s_ff.pin_sync[2] && !s_ff.trig_lvl;
        if (s_ff.pin_sync[1] == s_ff.pin_sync[2]) begin
            nxt_s.trig_lvl = s_ff.pin_sync[2];
        end
        // lock stays until power-on reset
        if (config_write_lock_cmd) begin
            nxt_s.lock = 1'b1;
        end
        // configuration writes
        if (reg_req.wr && cfg_ok) begin
            unique case (reg_req.sel)
                SEL_QGEN_CFG: nxt_s.qgen_cfg = {reg_req.wdata[7:5], 1'b0, reg_req.wdata[3:0]};
                SEL_WIN1_CFG: begin
                    nxt_s.win1_cfg = {1'b0, reg_req.wdata[WIN1_W-1:0]};
                    chg_set = nxt_s.win1_cfg != s_ff.win1_cfg;
                end
                SEL_WIN2_CFG: begin
                    nxt_s.win2_cfg = {3'h0, reg_req.wdata[WIN2_W-1:0]};
                    chg_set = nxt_s.win2_cfg != s_ff.win2_cfg;
                end
                default: ;
            endcase
        end
        // forced time-out from software, only in diagnostic state
        if (reg_req.wr && (reg_req.sel == SEL_STATUS) && diag_state && reg_req.wdata[ST_TOUT]) begin
            tout_set = 1'b1;
        end
        // status read clears time-out
        if (reg_req.rd) begin
            nxt_s.rdata = rd_mux;
            if (reg_req.sel == SEL_STATUS) begin
                tout_clr = 1'b1;
            end
        end
        // sequencer: first window then second; held while in reset state
        if (in_reset_state) begin
            nxt_s.phase = PH_WIN1;
            nxt_s.tick = '0;
            tout_clr = 1'b1;
            fresh = 1'b1;
        end else if (s_ff.tick >= win_last) begin
            nxt_s.tick = '0;
            if (s_ff.phase == PH_WIN1) begin
                nxt_s.phase = PH_WIN2;
            end else begin
                nxt_s.phase = PH_WIN1;
                seq_end = 1'b1;
            end
        end else begin
            nxt_s.tick = s_ff.tick + 1'b1;
        end
        // answer bytes
        if (ans_wr) begin
            nxt_s.ans_cnt = s_ff.ans_cnt + 1'b1;
            if (s_ff.ans_total != 3'h7) begin
                nxt_s.ans_total = s_ff.ans_total + 1'b1;
            end
            // a correct byte clears the error even when it arrives too late
            aerr_set = !correct;
            aerr_clr = correct;
            if (!correct || s_ff.ans_total >= ANSWERS_PER_SEQ) begin
                seqf_set = 1'b1;
                nxt_s.seq_bad = 1'b1;
            end
            if (s_ff.ans_total == ANSWERS_PER_SEQ - 3'h1 && s_ff.phase == PH_WIN1) begin
                early_set = 1'b1;
                seqf_set = 1'b1;
                nxt_s.seq_bad = 1'b1;
            end
        end
        // trigger mode
        if (!qa_mode && trig_rise && !in_reset_state) begin
            nxt_s.trig_seen = 1'b1;
            if (s_ff.phase == PH_WIN1) begin
                early_set = 1'b1;
                nxt_s.seq_bad = 1'b1;
            end
        end
        // sequence verdict
        if (seq_end) begin
            got_evt = qa_mode ? (s_ff.ans_total >= ANSWERS_PER_SEQ) : s_ff.trig_seen;
            if (!got_evt) begin
                tout_set = 1'b1;
                nxt_s.bad_evt = 1'b1;
            end else begin
                tout_clr = 1'b1;
                nxt_s.good_evt = !s_ff.seq_bad;
                nxt_s.bad_evt = s_ff.seq_bad;
            end
            fresh = 1'b1;
        end
        // new sequence starts clean
        if (fresh) begin
            nxt_s.ans_cnt = 2'h0;
            nxt_s.ans_total = 3'h0;
            nxt_s.trig_seen = 1'b0;
            nxt_s.seq_bad = 1'b0;
            aerr_clr = 1'b1;
        end
        nxt_s.aerr = (s_ff.aerr && !aerr_clr) || aerr_set;
        nxt_s.chg = (s_ff.chg && !seq_end) || chg_set;
        nxt_s.seqf = (s_ff.seqf && !(reg_req.rd && reg_req.sel == SEL_STATUS)) || seqf_set;
        nxt_s.tout = (s_ff.tout && !tout_clr) || tout_set;
        nxt_s.early = (s_ff.early && !(reg_req.rd && reg_req.sel == SEL_STATUS)) || early_set;
        // self-test reinitialisation restores status to reset values
        if (logic_selftest) begin
            nxt_s.ans_cnt = ANS_CNT_RST;
            nxt_s.aerr = 1'b0;
            nxt_s.chg = 1'b0;
            nxt_s.seqf = 1'b0;
            nxt_s.tout = 1'b0;
            nxt_s.early = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_ff <= '0;
            s_ff.qgen_cfg <= QGEN_CFG_RST;
            s_ff.win1_cfg <= WIN1_CFG_RST;
            s_ff.win2_cfg <= WIN2_CFG_RST;
            s_ff.ans_cnt <= ANS_CNT_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // generator is advanced once per good sequence in question-and-answer mode
    assign advance = s_ff.good_evt && qa_mode;

    qaw_question_gen u_qgen (
        .core_clk(core_clk),
        .reset(reset),
        .reinit(logic_selftest),
        .load_seed(load_seed),
        .seed(s_ff.qgen_cfg[SEED_LSB+:4]),
        .question_feedback_cfg(s_ff.qgen_cfg[QUESTION_FEEDBACK_CFG_LSB+:4]),
        .advance(advance),
        .token(token)
    );

    assign reg_rdata = s_ff.rdata;
    assign good_event = s_ff.good_evt;
    assign bad_event = s_ff.bad_evt;
    assign timeout_fail = s_ff.tout;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_cfg_lock: assert property (reg_req.wr && reg_req.sel == SEL_WIN1_CFG && s_ff.lock
        |=> s_ff.win1_cfg == $past(s_ff.win1_cfg)) else $error("locked window write took effect");
    chk_fail_thresh: assert property (reg_req.rd && reg_req.sel == SEL_QUESTION
        |=> reg_rdata[FAIL_TH_BIT] == ($past(fail_counter) >= 3'h5)) else $error("fail threshold wrong");
    chk_zero_window: assert property (zero_flag == ((s_ff.win1_cfg[6:0] == 7'h00) ||
        (s_ff.win2_cfg[4:0] == 5'h00))) else $error("zero window flag wrong");
    chk_chg_set: assert property (reg_req.wr && cfg_ok && reg_req.sel == SEL_WIN2_CFG &&
        reg_req.wdata[4:0] != s_ff.win2_cfg[4:0] && !logic_selftest |=> s_ff.chg) else $error("change missed");
    chk_aerr_set: assert property (ans_wr && !correct && !logic_selftest |=> s_ff.aerr)
        else $error("answer error not set");
    chk_tout_missing: assert property (seq_end && !got_evt && !logic_selftest
        |=> s_ff.tout && bad_event && !good_event) else $error("time-out not raised");
    chk_early_trig: assert property (!qa_mode && trig_rise && s_ff.phase == PH_WIN1 &&
        !in_reset_state && !logic_selftest |=> s_ff.early ##1 1'b1) else $error("early trigger missed");
    chk_reset_clr: assert property (in_reset_state && !(reg_req.wr && reg_req.sel == SEL_STATUS)
        |=> !s_ff.tout) else $error("time-out kept in reset state");
    chk_seed_load: assert property (load_seed && !logic_selftest |=> token == $past(s_ff.qgen_cfg[3:0]))
        else $error("seed not loaded");
    chk_reinit: assert property (logic_selftest |=> s_ff.ans_cnt == 2'h3 && !s_ff.aerr && !s_ff.tout)
        else $error("status not reinitialised");
    // further guards on the answer path, the question generator, the write gate and the status read
    chk_question_reinit: assert property (logic_selftest && !load_seed |=> token == 4'h0)
        else $error("question not reinitialised");
    chk_question_adv: assert property (advance && !s_ff.qgen_cfg[7] && !load_seed && !logic_selftest
        |=> token[3:1] == $past(token[2:0])) else $error("question did not advance");
    chk_diag_only: assert property (reg_req.wr && reg_req.sel == SEL_WIN1_CFG && !diag_state
        |=> s_ff.win1_cfg == $past(s_ff.win1_cfg)) else $error("window write outside diagnostic state");
    chk_aerr_clr: assert property (ans_wr && correct && !logic_selftest |=> !s_ff.aerr)
        else $error("answer error not cleared");
    chk_seqf_set: assert property (ans_wr && !correct && !logic_selftest |=> s_ff.seqf)
        else $error("sequence fault not set");
    chk_early_answers: assert property (ans_wr && s_ff.ans_total == 3'h3 && s_ff.phase == PH_WIN1 &&
        !logic_selftest |=> s_ff.early) else $error("early answers missed");
    chk_tout_read: assert property (reg_req.rd && reg_req.sel == SEL_STATUS && !tout_set &&
        !logic_selftest |=> !s_ff.tout) else $error("time-out kept after status read");
    chk_cnt_step: assert property (ans_wr && !fresh && !logic_selftest
        |=> s_ff.ans_cnt == $past(s_ff.ans_cnt) + 2'h1) else $error("answer count did not step");
endmodule // qaw_regs
`default_nettype wire

// [testbench/qaw_mcu.sv]
// microcontroller model: register accesses, answer bytes and the trigger pin
// assumes the register block takes one access per core_clk edge and answers a read one cycle later
`timescale 1ns/1ps
`default_nettype none
module qaw_mcu (
    // clock
    input wire logic core_clk,
    // register access
    output var qaw_pkg::qaw_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // trigger pin, driven push-pull by the controller
    output var logic error_trigger_pin
);
    import qaw_pkg::*;

    // idle at time zero so nothing is requested during reset
    initial begin
        reg_req = '0;
        error_trigger_pin = 1'b0;
    end

    // one write, held over exactly one taking edge
    task automatic wr(input logic [2:0] sel, input logic [7:0] data);
        @(negedge core_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, sel: qaw_reg_sel_t'(sel), wdata: data};
        @(negedge core_clk);
        reg_req.wr = 1'b0;
    endtask

    // one read; data is registered at the taking edge, so it is settled by the next falling edge
    task automatic rd(input logic [2:0] sel, output logic [7:0] data);
        @(negedge core_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, sel: qaw_reg_sel_t'(sel), wdata: 8'h00};
        @(negedge core_clk);
        reg_req.rd = 1'b0;
        data = reg_rdata;
    endtask

    // pin high long enough to pass the three-flop synchroniser
    task automatic trigger();
        @(negedge core_clk);
        error_trigger_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        error_trigger_pin = 1'b0;
    endtask

    // fetches the question first, then sends bytes first..last; a set bad bit spoils that byte
    task automatic answer(input int first, input int last, input logic [3:0] bad);
        logic [7:0] q;
        logic [1:0] idx;
        rd(3'h3, q);
        for (int i = first; i <= last; i++) begin
            idx = i[1:0];
            wr(3'h5, {q[3:0] ^ {2'h0, idx}, ~q[3:0]} ^ {8{bad[i]}});
        end
    endtask
endmodule // qaw_mcu
`default_nettype wire

// [testbench/test_qaw_regs.sv]
// self-checking bench for the watchdog register block
// assumes a window step of 2 cycles so each window set to 9 lasts 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_qaw_regs;
    import qaw_pkg::*;
    localparam int STEP = 2;
    logic core_clk, reset, diag_state, in_reset_state, auto_selftest_disable;
    logic config_write_lock_cmd, logic_selftest, qa_mode, error_trigger_pin;
    logic good_event, bad_event, timeout_fail;
    logic [2:0] fail_counter;
    logic [7:0] reg_rdata;
    qaw_reg_req_t reg_req;
    int bad_count, check_count, cycles;

    qaw_regs #(.WIN_STEP(STEP)) u_qaw_regs (.core_clk(core_clk), .reset(reset), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .diag_state(diag_state), .in_reset_state(in_reset_state),
        .auto_selftest_disable(auto_selftest_disable), .config_write_lock_cmd(config_write_lock_cmd),
        .logic_selftest(logic_selftest), .qa_mode(qa_mode), .fail_counter(fail_counter),
        .error_trigger_pin(error_trigger_pin), .good_event(good_event), .bad_event(bad_event),
        .timeout_fail(timeout_fail));
    qaw_mcu u_qaw_mcu (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .error_trigger_pin(error_trigger_pin));

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // masked byte compare; unknown bits never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        check_count++;
        if ((got & mask) !== (exp & mask)) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, got & mask, exp & mask);
        end
    endtask

    task automatic rchk(input logic [2:0] sel, input logic [7:0] exp, input logic [7:0] mask);
        logic [7:0] v;
        u_qaw_mcu.rd(sel, v);
        chk(v, exp, mask);
    endtask

    // waits for the end-of-sequence verdict; a missing one shows up as 00
    task automatic wait_evt(input logic exp_bad);
        int n;
        n = 0;
        @(negedge core_clk);
        while (good_event !== 1'b1 && bad_event !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk({6'h0, good_event, bad_event}, {6'h0, ~exp_bad, exp_bad}, 8'h03);
    endtask

    task automatic trig_seq(input int dly, input logic exp_bad);
        repeat (dly) @(negedge core_clk);
        u_qaw_mcu.trigger();
        wait_evt(exp_bad);
    endtask

    task automatic tout_chk(input logic exp);
        chk({7'h0, timeout_fail}, {7'h0, exp}, 8'h01);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        reset = 1'b1;
        diag_state = 1'b0;
        in_reset_state = 1'b0;
        auto_selftest_disable = 1'b0;
        config_write_lock_cmd = 1'b0;
        logic_selftest = 1'b0;
        qa_mode = 1'b0;
        fail_counter = 3'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        rchk(3'h0, 8'h00, 8'hFF);
        rchk(3'h1, 8'h7F, 8'hFF);
        rchk(3'h2, 8'h18, 8'hFF);
        rchk(3'h3, 8'h00, 8'hFF);
        rchk(3'h4, 8'hC0, 8'hFF);
        rchk(3'h6, 8'h00, 8'hFF);
        done("reset values");
        // sequencer held while windows change, so no sequence sees a half-written setup
        in_reset_state = 1'b1;
        u_qaw_mcu.wr(3'h1, 8'h05);
        rchk(3'h1, 8'h7F, 8'hFF);
        diag_state = 1'b1;
        u_qaw_mcu.wr(3'h0, 8'h75);
        rchk(3'h0, 8'h65, 8'hFF);
        u_qaw_mcu.wr(3'h1, 8'h89);
        rchk(3'h1, 8'h09, 8'hFF);
        u_qaw_mcu.wr(3'h2, 8'h00);
        rchk(3'h4, 8'h18, 8'h18);
        u_qaw_mcu.wr(3'h2, 8'hE9);
        rchk(3'h2, 8'h09, 8'hFF);
        rchk(3'h4, 8'h08, 8'h18);
        u_qaw_mcu.wr(3'h7, 8'hFF);
        rchk(3'h3, 8'h00, 8'h0F);
        auto_selftest_disable = 1'b1;
        repeat (2) @(negedge core_clk);
        rchk(3'h3, 8'h05, 8'h0F);
        auto_selftest_disable = 1'b0;
        in_reset_state = 1'b0;
        config_write_lock_cmd = 1'b1;
        @(negedge core_clk);
        config_write_lock_cmd = 1'b0;
        u_qaw_mcu.wr(3'h1, 8'h05);
        rchk(3'h1, 8'h09, 8'hFF);
        done("configuration");
        for (int i = 0; i < 8; i++) begin
            fail_counter = i[2:0];
            rchk(3'h3, (i >= 5) ? 8'h80 : 8'h00, 8'h80);
        end
        fail_counter = 3'h0;
        done("fail threshold");
        wait_evt(1'b1);
        @(negedge core_clk);
        tout_chk(1'b1);
        trig_seq(24, 1'b0);
        @(negedge core_clk);
        tout_chk(1'b0);
        rchk(3'h4, 8'h00, 8'h0B);
        wait_evt(1'b1);
        rchk(3'h4, 8'h02, 8'h02);
        rchk(3'h4, 8'h00, 8'h02);
        wait_evt(1'b1);
        trig_seq(2, 1'b1);
        rchk(3'h4, 8'h01, 8'h01);
        done("trigger mode");
        diag_state = 1'b0;
        u_qaw_mcu.wr(3'h4, 8'h02);
        tout_chk(1'b0);
        diag_state = 1'b1;
        u_qaw_mcu.wr(3'h4, 8'h02);
        tout_chk(1'b1);
        rchk(3'h4, 8'h02, 8'h02);
        @(negedge core_clk);
        tout_chk(1'b0);
        done("forced time-out");
        wait_evt(1'b1);
        u_qaw_mcu.wr(3'h5, 8'h00);
        rchk(3'h4, 8'h00, 8'hC0);
        qa_mode = 1'b1;
        wait_evt(1'b1);
        repeat (24) @(negedge core_clk);
        u_qaw_mcu.answer(0, 3, 4'h0);
        wait_evt(1'b0);
        rchk(3'h3, 8'h0A, 8'h0F);
        rchk(3'h4, 8'h00, 8'hE7);
        u_qaw_mcu.answer(0, 3, 4'h0);
        wait_evt(1'b1);
        rchk(3'h4, 8'h01, 8'h01);
        u_qaw_mcu.answer(0, 1, 4'h2);
        rchk(3'h4, 8'hA4, 8'hE4);
        u_qaw_mcu.answer(2, 2, 4'h0);
        rchk(3'h4, 8'hC0, 8'hE0);
        wait_evt(1'b1);
        rchk(3'h4, 8'h02, 8'h02);
        done("answer mode");
        logic_selftest = 1'b1;
        @(negedge core_clk);
        logic_selftest = 1'b0;
        rchk(3'h4, 8'hC0, 8'hFF);
        rchk(3'h3, 8'h00, 8'hFF);
        done("self-test reinit");
        results();
    end
endmodule // test_qaw_regs
`default_nettype wire
